// ---- verilog/ptio_defs.vh ----
`ifndef PTIO_DEFS_VH
`define PTIO_DEFS_VH

// register byte offsets
`define PTIO_OFF_CTRL      12'h000
`define PTIO_OFF_PRESCALE  12'h004
`define PTIO_OFF_STATUS    12'h008
`define PTIO_OFF_INPUTS    12'h00C
`define PTIO_OFF_EVENTS    12'h010

// control fields
`define PTIO_CTRL_TRIG_LSB     0
`define PTIO_CTRL_TRIG_MSB     1
`define PTIO_CTRL_DIRMODE_BIT  2
`define PTIO_CTRL_MOTMODE_BIT  3
`define PTIO_CTRL_PROGOUT_BIT  4
`define PTIO_CTRL_RESET        5'h00

// trigger option codes
`define PTIO_TRIG_PEDAL    2'h0
`define PTIO_TRIG_EDGEPAIR 2'h1
`define PTIO_TRIG_LAUNCH   2'h2

// timing
`define PTIO_CLK_HZ        250000000
`define PTIO_TICK_MS       50
`define PTIO_STABLE_MS     100
`define PTIO_TICK_CYCLES   ((`PTIO_CLK_HZ / 1000) * `PTIO_TICK_MS)
`define PTIO_STABLE_TICKS  (`PTIO_STABLE_MS / `PTIO_TICK_MS)
`define PTIO_PRESCALE_RESET 24'hBEBC20

`endif

// ---- verilog/ptio_filter.v ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// deglitch filter for one sampled input
// ----------------------------------------------------------------------------
module ptio_filter (
    input  wire clk_i,
    input  wire arst_n_i,
    input  wire tick_i,
    input  wire sample_i,
    output reg  level_o,
    output reg  rise_o,
    output reg  fall_o
);
    reg cand;
    reg cnt;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
            cand    <= 1'b0;
            cnt     <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (tick_i) begin
                if (sample_i != cand) begin
                    cand <= sample_i;
                    cnt  <= 1'b0;
                end else if (sample_i != level_o) begin
                    // three equal samples, 50 ms apart, span 100 ms
                    if (cnt) begin
                        level_o <= sample_i;
                        rise_o  <= sample_i;
                        fall_o  <= !sample_i;
                        cnt     <= 1'b0;
                    end else begin
                        cnt <= 1'b1;
                    end
                end else begin
                    cnt <= 1'b0;
                end
            end
        end
    end
endmodule // ptio_filter
`default_nettype wire

// ---- verilog/ptio_top.v ----
// Overview of operation
// - sample 50 ms, accept after 100 ms
// - edge is change of accepted level
// - high-low falling, low-high rising
// - ignore trigger/direction while editing
// - ignore trigger/direction during alarm
// - trigger activation acts as start/stop
// - pedal: falling toggles start/stop
// - edge-pair: falling stops, rising starts
// - launch-only: falling starts only when allowed
// - motor mode 0: high while pumping
// - motor mode 1: pumping or pause timer
// - direction output high when infusing
// - direction input only where key accepted
// - alternating: fall to infuse, rise withdraw
// - paired: rise to infuse, fall withdraw
// - program pins also user levels
// - trigger option selected by code
// - event falling edge drives jump
// - program input low drives branch
`timescale 1ns/1ps
`default_nettype none
`include "ptio_defs.vh"
module ptio_top (
    input  wire        clk_i,
    input  wire        arst_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        trig_pin_i,
    input  wire        dir_pin_i,
    input  wire        event_pin_i,
    input  wire        prog_in_pin_i,
    input  wire        editing_i,
    input  wire        alarm_i,
    input  wire        running_i,
    input  wire        start_allowed_i,
    input  wire        pumping_i,
    input  wire        pause_timer_i,
    input  wire        dir_key_ok_i,
    input  wire        infuse_i,
    input  wire        jump_fall_arm_i,
    input  wire        branch_arm_i,
    output reg         prog_out_pin_o,
    output reg         motor_pin_o,
    output reg         dir_pin_o,
    output reg         start_o,
    output reg         stop_o,
    output reg         set_infuse_o,
    output reg         set_withdraw_o,
    output reg         jump_o,
    output reg         branch_o
);
    // ------------------------------------------------------------------------
    // registers and synchronisers
    // ------------------------------------------------------------------------
    reg  [4:0]  ctrl;
    reg  [23:0] prescale;
    reg  [23:0] div_cnt;
    reg         tick;
    reg  [3:0]  sync1;
    reg  [3:0]  sync2;
    reg  [3:0]  ev_rise;
    reg  [3:0]  ev_fall;
    wire [3:0]  lvl;
    wire [3:0]  rise;
    wire [3:0]  fall;
    wire [1:0]  trig_mode = ctrl[`PTIO_CTRL_TRIG_MSB:`PTIO_CTRL_TRIG_LSB];
    wire        paired    = ctrl[`PTIO_CTRL_DIRMODE_BIT];
    wire        blocked   = editing_i | alarm_i;
    wire        wr_en     = psel_i & penable_i & pwrite_i;
    wire        rd_en     = psel_i & penable_i & !pwrite_i;
    wire [3:0]  pins = {prog_in_pin_i, event_pin_i, dir_pin_i, trig_pin_i};

    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `PTIO_OFF_CTRL) | (a == `PTIO_OFF_PRESCALE) |
                         (a == `PTIO_OFF_STATUS) | (a == `PTIO_OFF_INPUTS) |
                         (a == `PTIO_OFF_EVENTS);
        end
    endfunction

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end

    // ------------------------------------------------------------------------
    // sampling tick
    // ------------------------------------------------------------------------
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt <= 24'h000000;
            tick    <= 1'b0;
        end else if (div_cnt >= prescale - 24'h000001) begin
            div_cnt <= 24'h000000;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 24'h000001;
            tick    <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
            ptio_filter u_filt (
                .clk_i    (clk_i),
                .arst_n_i (arst_n_i),
                .tick_i   (tick),
                .sample_i (sync2[gi]),
                .level_o  (lvl[gi]),
                .rise_o   (rise[gi]),
                .fall_o   (fall[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // trigger, direction and program actions
    // ------------------------------------------------------------------------
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_o        <= 1'b0;
            stop_o         <= 1'b0;
            set_infuse_o   <= 1'b0;
            set_withdraw_o <= 1'b0;
            jump_o         <= 1'b0;
            branch_o       <= 1'b0;
            motor_pin_o    <= 1'b0;
            dir_pin_o      <= 1'b0;
            prog_out_pin_o <= 1'b0;
        end else begin
            start_o        <= 1'b0;
            stop_o         <= 1'b0;
            set_infuse_o   <= 1'b0;
            set_withdraw_o <= 1'b0;
            if (!blocked) begin
                case (trig_mode)
                    `PTIO_TRIG_PEDAL: begin
                        start_o <= fall[0] & !running_i;
                        stop_o  <= fall[0] & running_i;
                    end
                    `PTIO_TRIG_EDGEPAIR: begin
                        start_o <= rise[0];
                        stop_o  <= fall[0];
                    end
                    `PTIO_TRIG_LAUNCH: begin
                        start_o <= fall[0] & start_allowed_i;
                    end
                    default: begin
                        start_o <= 1'b0;
                    end
                endcase
                if (dir_key_ok_i) begin
                    if (!paired) begin
                        set_infuse_o   <= fall[1] & !infuse_i;
                        set_withdraw_o <= rise[1] & infuse_i;
                    end else begin
                        set_infuse_o   <= rise[1] & !infuse_i;
                        set_withdraw_o <= fall[1] & infuse_i;
                    end
                end
            end
            jump_o   <= fall[2] & jump_fall_arm_i;
            branch_o <= branch_arm_i & tick & !lvl[3];
            motor_pin_o <= pumping_i |
                (ctrl[`PTIO_CTRL_MOTMODE_BIT] & pause_timer_i);
            dir_pin_o      <= infuse_i;
            prog_out_pin_o <= ctrl[`PTIO_CTRL_PROGOUT_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl     <= `PTIO_CTRL_RESET;
            prescale <= `PTIO_PRESCALE_RESET;
            ev_rise  <= 4'h0;
            ev_fall  <= 4'h0;
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            // answer in the access phase only, one wait state after it opens
            pready_o  <= psel_i & penable_i & !pready_o;
            pslverr_o <= psel_i & penable_i & !pready_o
                         & !known_addr(paddr_i);
            prdata_o  <= 32'h00000000;
            if (wr_en & pready_o & (paddr_i == `PTIO_OFF_CTRL))
                ctrl <= pwdata_i[4:0];
            if (wr_en & pready_o & (paddr_i == `PTIO_OFF_PRESCALE)
                & (pwdata_i[23:0] != 24'h000000))
                prescale <= pwdata_i[23:0];
            // set wins over a write-one-to-clear in the same cycle
            if (wr_en & pready_o & (paddr_i == `PTIO_OFF_EVENTS)) begin
                ev_rise <= (ev_rise & ~pwdata_i[3:0]) | rise;
                ev_fall <= (ev_fall & ~pwdata_i[11:8]) | fall;
            end else begin
                ev_rise <= ev_rise | rise;
                ev_fall <= ev_fall | fall;
            end
            if (rd_en & !pready_o) begin
                case (paddr_i)
                    `PTIO_OFF_CTRL:     prdata_o <= {27'h0, ctrl};
                    `PTIO_OFF_PRESCALE: prdata_o <= {8'h00, prescale};
                    `PTIO_OFF_STATUS:   prdata_o <= {26'h0, motor_pin_o,
                        dir_pin_o, running_i, alarm_i, editing_i,
                        prog_out_pin_o};
                    `PTIO_OFF_INPUTS:   prdata_o <= {28'h0, lvl};
                    `PTIO_OFF_EVENTS:   prdata_o <= {20'h0, ev_fall,
                        4'h0, ev_rise};
                    default:            prdata_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // ptio_top
`default_nettype wire

// ---- bench/ptio_ext.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// external equipment on the pins
// ----
module ptio_ext #(parameter int HOLD = 12) (
    input  wire logic       clk_i,
    input  wire logic [3:0] want_i,
    input  wire logic       glitch_i,
    output logic      [3:0] pin_o
);
    logic [3:0] lvl = 4'h0;
    int         cnt = 0;
    // a new level waits until the old one stood long enough
    always @(posedge clk_i) begin
        if (cnt < HOLD)
            cnt <= cnt + 1;
        else if (want_i != lvl) begin
            lvl <= want_i;
            cnt <= 0;
        end
    end
    // glitch breaks the hold on purpose, trigger pin only
    assign pin_o = lvl ^ {3'h0, glitch_i};
endmodule // ptio_ext
`default_nettype wire

// ---- bench/ptio_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module ptio_checker (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic start_o,
    input wire logic stop_o,
    input wire logic set_infuse_o,
    input wire logic set_withdraw_o,
    input wire logic editing_i,
    input wire logic alarm_i,
    input wire logic pumping_i,
    input wire logic pause_timer_i,
    input wire logic dir_key_ok_i,
    input wire logic infuse_i,
    input wire logic jump_fall_arm_i,
    input wire logic motor_pin_o,
    input wire logic dir_pin_o,
    input wire logic jump_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_apb_wait: assert property
        (psel_i && penable_i && !pready_o |=> pready_o) else $error("late");
    a_start_pulse: assert property (start_o |=> !start_o)
        else $error("start pulse too long");
    a_stop_pulse: assert property (stop_o |=> !stop_o)
        else $error("stop pulse too long");
    a_action_blocked: assert property
        ((start_o || stop_o) |-> !$past(editing_i || alarm_i))
        else $error("action while blocked");
    a_to_infuse: assert property
        (set_infuse_o |-> !$past(infuse_i) && $past(dir_key_ok_i))
        else $error("bad infuse switch");
    a_to_withdraw: assert property
        (set_withdraw_o |-> $past(infuse_i) && $past(dir_key_ok_i))
        else $error("bad withdraw switch");
    a_motor_high: assert property ($past(pumping_i) |-> motor_pin_o)
        else $error("motor low while pumping");
    a_motor_cause: assert property
        (motor_pin_o |-> $past(pumping_i || pause_timer_i))
        else $error("motor high without cause");
    a_dir_out: assert property (dir_pin_o == $past(infuse_i))
        else $error("direction output wrong");
    a_jump_armed: assert property (jump_o |-> $past(jump_fall_arm_i))
        else $error("jump without arm");
endmodule // ptio_checker
bind ptio_top ptio_checker chk_u (.*);
`default_nettype wire

// ---- bench/test_ptio_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ptio_defs.vh"
module test_ptio_top;
    logic clk_i = 0, arst_n_i = 0, glitch = 0, rerr;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
    logic editing_i = 0, alarm_i = 0, running_i = 0, start_allowed_i = 0;
    logic pumping_i = 0, pause_timer_i = 0, dir_key_ok_i = 0, infuse_i = 0;
    logic jump_fall_arm_i = 0, branch_arm_i = 0;
    logic prog_out_pin_o, motor_pin_o, dir_pin_o, start_o, stop_o;
    logic set_infuse_o, set_withdraw_o, jump_o, branch_o;
    logic [3:0] want = 4'h0, pin;
    logic [7:0] n_st = 0, n_sp = 0, n_in = 0, n_wd = 0, n_jp = 0, n_br = 0;
    int num_errors = 0, n_compared = 0;
    wire trig_pin_i = pin[0], dir_pin_i = pin[1];
    wire event_pin_i = pin[2], prog_in_pin_i = pin[3];
    always #2 clk_i = ~clk_i;
    // ----
    // pulse counters
    // ----
    // outputs are unknown before the first reset edge, so count after it
    always @(posedge clk_i) begin
        if (arst_n_i) begin
            n_st <= n_st + {7'h00, start_o};
            n_sp <= n_sp + {7'h00, stop_o};
            n_in <= n_in + {7'h00, set_infuse_o};
            n_wd <= n_wd + {7'h00, set_withdraw_o};
            n_jp <= n_jp + {7'h00, jump_o};
            n_br <= n_br + {7'h00, branch_o};
        end
    end
    ptio_ext #(.HOLD(12)) ext_u (.clk_i(clk_i), .want_i(want),
        .glitch_i(glitch), .pin_o(pin));
    ptio_top dut_u (.*);
    // ----
    // tasks
    // ----
    task test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, rdat);
    endtask
    task pin_set(input int b, input logic v);
        want[b] <= v;
        repeat (40) @(posedge clk_i);
    endtask
    // ----
    // tests
    // ----
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd("ctrl", `PTIO_OFF_CTRL, 32'h0);
        apb(1'b1, `PTIO_OFF_PRESCALE, 32'h4);
        rd("prescale", `PTIO_OFF_PRESCALE, 32'h4);
        rd("inputs", `PTIO_OFF_INPUTS, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk("slverr", 1, rerr);
        pin_set(0, 1);
        pin_set(0, 0);
        chk("start", 1, n_st);
        running_i <= 1'b1;
        pin_set(0, 1);
        pin_set(0, 0);
        chk("stop", 1, n_sp);
        pin_set(0, 1);
        // shorter than one tick, so never seen twice
        glitch <= 1'b1;
        repeat (3) @(posedge clk_i);
        glitch <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk("glitch", 1, n_sp);
        alarm_i <= 1'b1;
        pin_set(0, 0);
        alarm_i <= 1'b0;
        editing_i <= 1'b1;
        pin_set(0, 1);
        pin_set(0, 0);
        editing_i <= 1'b0;
        chk("blocked", 1, n_sp);
        $display("test pedal done");
        apb(1'b1, `PTIO_OFF_CTRL, {30'h0, `PTIO_TRIG_EDGEPAIR});
        pin_set(0, 1);
        chk("start", 2, n_st);
        pin_set(0, 0);
        chk("stop", 2, n_sp);
        apb(1'b1, `PTIO_OFF_CTRL, {30'h0, `PTIO_TRIG_LAUNCH});
        pin_set(0, 1);
        pin_set(0, 0);
        start_allowed_i <= 1'b1;
        pin_set(0, 1);
        pin_set(0, 0);
        chk("start", 3, n_st);
        chk("stop", 2, n_sp);
        $display("test trigger done");
        dir_key_ok_i <= 1'b1;
        pin_set(1, 1);
        pin_set(1, 0);
        chk("infuse", 1, n_in);
        infuse_i <= 1'b1;
        pin_set(1, 1);
        chk("withdraw", 1, n_wd);
        apb(1'b1, `PTIO_OFF_CTRL, 32'h6);
        pin_set(1, 0);
        chk("withdraw", 2, n_wd);
        infuse_i <= 1'b0;
        pin_set(1, 1);
        chk("infuse", 2, n_in);
        rd("inputs", `PTIO_OFF_INPUTS, 32'h2);
        dir_key_ok_i <= 1'b0;
        infuse_i <= 1'b1;
        pin_set(1, 0);
        chk("withdraw", 2, n_wd);
        $display("test direction done");
        jump_fall_arm_i <= 1'b1;
        pin_set(2, 1);
        pin_set(2, 0);
        chk("jump", 1, n_jp);
        branch_arm_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("branch", 1, n_br != 0);
        pin_set(3, 1);
        rdat = {24'h0, n_br};
        repeat (20) @(posedge clk_i);
        chk("branch", rdat, {24'h0, n_br});
        rd("events", `PTIO_OFF_EVENTS, 32'h0000070F);
        apb(1'b1, `PTIO_OFF_EVENTS, 32'h00000F0F);
        rd("events", `PTIO_OFF_EVENTS, 32'h00000000);
        apb(1'b1, `PTIO_OFF_CTRL, 32'h18);
        pause_timer_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("motor", 1, motor_pin_o);
        chk("progout", 1, prog_out_pin_o);
        chk("dirout", 1, dir_pin_o);
        rd("status", `PTIO_OFF_STATUS, 32'h00000039);
        apb(1'b1, `PTIO_OFF_CTRL, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("motor", 0, motor_pin_o);
        pumping_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("motor", 1, motor_pin_o);
        $display("test outputs done");
        test_done();
    end
endmodule // test_ptio_top
`default_nettype wire
